// [dv/io_rom_model.sv]
// Program ROM and I/O register space that face the core.
`timescale 1ns/1ps
module io_rom_model (
  input wire logic core_clk,
  input wire logic [13:0] rom_addr,
  output logic [7:0] rom_data,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  output logic [7:0] io_rdata
);
  // Program bytes, loaded by the bench before reset ends.
  logic [7:0] mem [0:1023];
  // Filler that changes every cycle outside a read.
  logic [7:0] junk_ff;
  // The ROM answers combinationally; only 1K is populated.
  assign rom_data = mem[rom_addr[9:0]];
  // Each register reads as its address mixed with a constant.
  assign io_rdata = io_rd ? (io_addr ^ 8'h5A) : junk_ff;
  // A late sample sees garbage, never a stale value.
  always @(posedge core_clk) begin
    junk_ff <= (junk_ff === 8'hxx) ? 8'hA5 : ~junk_ff + 8'h3B;
  end
endmodule

// [dv/tb.sv]
// Self-checking bench: runs a program and compares every port write.
`timescale 1ns/1ps
`include "cpu_core_regs.svh"
module tb;
  logic core_clk, nrst, irq_req, io_wr_ff, io_rd_ff, irq_ack_ff, int_en_ff, halted_ff;
  logic [7:0] rom_data, io_rdata, io_addr_ff, io_wdata_ff;
  logic [`PC_W-1:0] rom_addr_ff, irq_vector;
  int fails, checks, pc, acc, c, cyc, e, x, k, m, ret, p;
  int exp_q[$];
  int ops[7] = '{8'h01, 8'h04, 8'h07, 8'h0A, 8'h0D, 8'h10, 8'h13};

  cpu_core DUT (.core_clk(core_clk), .nrst(nrst), .rom_data(rom_data),
    .rom_addr_ff(rom_addr_ff), .io_rdata(io_rdata), .io_addr_ff(io_addr_ff),
    .io_wdata_ff(io_wdata_ff), .io_wr_ff(io_wr_ff), .io_rd_ff(io_rd_ff),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack_ff(irq_ack_ff),
    .int_en_ff(int_en_ff), .halted_ff(halted_ff));
  io_rom_model rom_u (.core_clk(core_clk), .rom_addr(rom_addr_ff), .rom_data(rom_data),
    .io_rd(io_rd_ff), .io_addr(io_addr_ff), .io_rdata(io_rdata));

  // A 50 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Program builders; the reference model tracks acc and carry.
  task automatic emit(input int b);
    rom_u.mem[pc] = b[7:0];
    pc++;
  endtask
  task automatic op2(input int o, input int v);
    emit(o);
    emit(v);
  endtask
  // Port write of the accumulator; only defined addresses are used.
  task automatic wr(input int a);
    op2(8'h2A, a);
    exp_q.push_back((a << 8) | acc);
  endtask
  function automatic int alu(input int o, input int a, input int b);
    int s;
    s = a;
    case (o)
      8'h01: begin s = a + b; c = s > 255; end
      8'h04: begin s = a + b + c; c = s > 255; end
      8'h07: begin s = a - b; c = a < b; end
      8'h0A: begin s = a - b - c; c = a < b + c; end
      8'h0D: s = a | b;
      8'h10: s = a & b;
      default: s = a ^ b;
    endcase
    return s & 255;
  endfunction
  task automatic check(input logic [7:0] got, input int ex, input string what);
    checks++;
    if (got !== ex[7:0]) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, ex[7:0]);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watch writes and the interrupt handshake in mid-cycle.
  always @(negedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done();
    end
    if (io_wr_ff === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
      check(io_addr_ff, e >> 8, "io addr");
      check(io_wdata_ff, e, "io data");
      if (io_addr_ff === 8'h30) irq_req <= 1'b1;
      if (io_addr_ff === 8'h31) check({7'h0, int_en_ff}, 1, "unmask");
    end
    if (irq_ack_ff === 1'b1) begin
      irq_req <= 1'b0;
      check(rom_addr_ff[7:0], 8'h00, "vector lo");
      check({2'h0, rom_addr_ff[13:8]}, 1, "vector hi");
      check({7'h0, int_en_ff}, 0, "masked");
    end
  end

  // Build the program, reset, run to the halt.
  initial begin
    nrst = 1'b0;
    irq_req = 1'b0;
    irq_vector = 14'h0100;
    x = $urandom(32'h6401);
    for (int i = 0; i < 1024; i++) rom_u.mem[i] = 8'h20;
    acc = $urandom & 255;
    op2(8'h19, acc);
    wr(8'h10);
    op2(8'h29, 8'h05);
    acc = 8'h5F;
    wr(8'h11);
    x = 8'h40 + ($urandom % 32);
    op2(8'h1C, x);
    op2(8'h39, 0);
    exp_q.push_back((x << 8) | acc);
    op2(8'h39, 3);
    exp_q.push_back((((x + 3) & 255) << 8) | acc);
    foreach (ops[i]) begin
      k = $urandom & 255;
      op2(ops[i], k);
      acc = alu(ops[i], acc, k);
      wr(8'h12);
    end
    k = $urandom & 255;
    op2(8'h16, k);
    c = acc < k;
    op2(8'h04, 0);
    acc = (acc + c) & 255;
    wr(8'h12);
    m = acc;
    op2(8'h31, 8'h50);
    op2(8'h19, 0);
    op2(8'h02, 8'h50);
    wr(8'h13);
    op2(8'h32, 7);
    op2(8'h19, 0);
    op2(8'h1A, (x + 7) & 255);
    wr(8'h14);
    emit(8'h2D);
    op2(8'h19, 0);
    op2(8'h1A, 8'hFF);
    wr(8'h15);
    emit(8'h2C);
    op2(8'h19, 0);
    emit(8'h40);
    wr(8'h16);
    ret = pc + 2;
    op2(8'h52, 8'h00);
    p = pc;
    pc = 512;
    op2(8'h1A, 0);
    acc = ret & 255;
    wr(8'h17);
    op2(8'h1A, 1);
    acc = ((m == 0) << 6) | (ret >> 8);
    wr(8'h18);
    emit(8'h3F);
    pc = p;
    wr(8'h30);
    emit(8'h72);
    repeat (8) emit(8'h20);
    p = pc;
    pc = 256;
    acc = 8'h77;
    op2(8'h19, acc);
    wr(8'h20);
    emit(8'h73);
    pc = p;
    wr(8'h31);
    emit(8'h00);
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 3000 && halted_ff !== 1'b1; i++) @(negedge core_clk);
    check({7'h0, halted_ff}, 1, "halted");
    check(8'(exp_q.size()), 0, "writes left");
    test_done();
  end
endmodule

// [verilog/cpu_core.sv]
// Instruction decode and execution control of the 8-bit core.
`timescale 1ns/1ps
`include "cpu_core_regs.svh"
module cpu_core
  import cpu_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] rom_data,
  output logic [`PC_W-1:0] rom_addr_ff,
  input wire logic [7:0] io_rdata,
  output logic [7:0] io_addr_ff,
  output logic [7:0] io_wdata_ff,
  output logic io_wr_ff,
  output logic io_rd_ff,
  input wire logic irq_req,
  input wire logic [`PC_W-1:0] irq_vector,
  output logic irq_ack_ff,
  output logic int_en_ff,
  output logic halted_ff
);
  // Reset synchroniser stages.
  logic meta_nrst_ff;
  logic sync_nrst_ff;
  // Sequencer state.
  phase_t phase_ff;
  logic [3:0] step_ff;
  // Instruction bytes and architectural registers.
  logic [7:0] opc_ff;
  logic [7:0] opnd_ff;
  logic [7:0] acc_ff;
  logic [7:0] x_ff;
  logic [7:0] dsp_ff;
  logic [7:0] psp_ff;
  logic [7:0] hold_ff;
  logic [`PC_W-1:0] pc_ff;
  logic c_ff;
  logic z_ff;
  // Decoded fields of the current opcode.
  cls_t cls;
  logic [3:0] len;
  logic two;
  logic mem;
  logic idx;
  logic [2:0] sel;
  // Next values and datapath results.
  logic [`PC_W-1:0] nxt_pc;
  logic [8:0] alu_r;
  logic [8:0] sh_r;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;

  // Release the reset through two flops; only the second is used.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_nrst_ff <= 1'b0;
      sync_nrst_ff <= 1'b0;
    end else begin
      meta_nrst_ff <= 1'b1;
      sync_nrst_ff <= meta_nrst_ff;
    end
  end

  // Group and mode of the accumulator arithmetic opcodes.
  wire [4:0] op_m1 = opc_ff[4:0] - 5'h01;
  wire [2:0] grp = 3'(op_m1 / 5'h03);
  wire [1:0] amode = 2'(op_m1 % 5'h03);
  // Register or memory target of increment and decrement.
  wire [1:0] tgt = opc_ff[1:0];
  wire id_mem = (tgt == 2'h3) || (tgt == 2'h0);

  // Opcode decode: class, cycle count, operand byte and addressing.
  always_comb begin
    cls = C_NOP;
    len = `CYC_BASE;
    two = 1'b0;
    mem = 1'b0;
    idx = 1'b0;
    sel = 3'h0;
    unique case (opc_ff) inside
      8'h00: begin
        cls = C_HALT;
        len = `CYC_LONG;
      end
      // Groups of three: data, direct, indexed; so 0B is the direct borrow form.
      [8'h01:8'h18]: begin
        cls = C_ALU;
        two = 1'b1;
        mem = amode != 2'h0;
        idx = amode == 2'h2;
        sel = grp;
        len = (amode == 2'h0 ? `CYC_BASE : amode == 2'h1 ? `CYC_MID : `CYC_LONG)
              + {3'h0, grp == 3'h7};
      end
      [8'h19:8'h1B]: begin
        cls = C_LDA;
        two = 1'b1;
        mem = opc_ff != 8'h19;
        idx = opc_ff == 8'h1B;
        len = opc_ff == 8'h19 ? `CYC_BASE : opc_ff == 8'h1A ? `CYC_SHORT : `CYC_MID;
      end
      8'h1C, 8'h1D: begin
        cls = C_LDX;
        two = 1'b1;
        mem = opc_ff[0];
        len = opc_ff[0] ? `CYC_SHORT : `CYC_BASE;
      end
      8'h1E, 8'h20: cls = C_NOP;
      8'h1F: cls = C_XPG;
      [8'h21:8'h28]: begin
        cls = opc_ff <= 8'h24 ? C_INC : C_DEC;
        two = id_mem;
        mem = id_mem;
        idx = tgt == 2'h0;
        len = tgt == 2'h3 ? `CYC_LONG : tgt == 2'h0 ? `CYC_RMWX : `CYC_BASE;
      end
      8'h29: begin
        cls = C_IO_READ_OP;
        two = 1'b1;
        len = `CYC_SHORT;
      end
      8'h2A: begin
        cls = C_IO_WRITE_OP;
        two = 1'b1;
        len = `CYC_SHORT;
      end
      8'h2B, 8'h2C: cls = C_POP;
      8'h2D, 8'h2E: begin
        cls = C_PUSH;
        len = `CYC_SHORT;
      end
      8'h2F, 8'h30: begin
        cls = opc_ff[0] ? C_SWX : C_SWD;
        len = `CYC_SHORT;
      end
      8'h31, 8'h32: begin
        cls = C_ST;
        two = 1'b1;
        idx = opc_ff[1];
        len = opc_ff[1] ? `CYC_MID : `CYC_SHORT;
      end
      [8'h33:8'h38]: begin
        cls = C_RMW;
        two = 1'b1;
        mem = 1'b1;
        idx = !opc_ff[0];
        sel = 3'(8'h04 + ((opc_ff - 8'h33) >> 1));
        len = opc_ff[0] ? `CYC_LONG : `CYC_RMWX;
      end
      8'h39: begin
        cls = C_INDEXED_IO_WRITE_OP;
        two = 1'b1;
        len = `CYC_MID;
      end
      [8'h3A:8'h3E]: cls = C_SHF;
      8'h3F, 8'h73: begin
        cls = opc_ff[0] && opc_ff[6] ? C_INTERRUPT_EXIT : C_RET;
        len = `CYC_RMWX;
      end
      8'h40: cls = C_MAX;
      8'h41: cls = C_MXA;
      8'h60: cls = C_MPSP;
      8'h70: cls = C_DI;
      8'h72: cls = C_EI;
      [8'h50:8'h5F], [8'h90:8'h9F]: begin
        cls = C_CALL;
        two = 1'b1;
        len = `CYC_CALL;
      end
      [8'h80:8'h8F], [8'hA0:8'hDF]: begin
        cls = opc_ff[7:4] == 4'h8 ? C_JMP : C_JCC;
        two = 1'b1;
        len = `CYC_SHORT;
      end
      [8'hE0:8'hEF]: begin
        cls = C_ACCUMULATOR_JUMP;
        two = 1'b1;
        len = `CYC_LONG;
      end
      [8'hF0:8'hFF]: begin
        cls = C_TBL;
        two = 1'b1;
        len = `CYC_TBL;
      end
      // Undefined opcodes behave as a basic four-cycle no-operation.
      default: cls = C_NOP;
    endcase
  end

  // Sequencer timing terms.
  wire run = phase_ff == PH_RUN;
  wire s0 = step_ff == `STEP_FETCH;
  wire s1 = step_ff == `STEP_OPND;
  wire s2 = step_ff == `STEP_MEM;
  wire s3 = step_ff == `STEP_EXM;
  wire [3:0] ex_step = mem ? `STEP_EXM : two ? `STEP_MEM : `STEP_OPND;
  wire ex = run && step_ff == ex_step;
  wire last = run ? step_ff == len - 4'h1 : phase_ff == PH_IRQ && step_ff == `CYC_IRQ - 4'h1;
  // Effective RAM address of direct and indexed operands.
  wire [7:0] ea = idx ? opnd_ff + x_ff : opnd_ff;
  wire [7:0] opnd_val = mem ? ram_rdata : opnd_ff;
  // Saved stack bytes: low counter, then flags over the upper counter bits.
  wire [7:0] byte1 = pc_ff[7:0];
  wire [7:0] byte2 = {c_ff, z_ff, pc_ff[`PC_W-1:8]};
  // Branch targets; the low opcode nibble holds address bits.
  wire [`PC_W-1:0] near_tgt = {pc_ff[`PC_W-1:12], opc_ff[3:0], opnd_ff};
  wire [`PC_W-1:0] call_tgt = {pc_ff[`PC_W-1:13], opc_ff[7], opc_ff[3:0], opnd_ff};
  wire [`PC_W-1:0] acc_tgt = near_tgt + {6'h00, acc_ff};
  wire cond_ok = opc_ff[5] ? (z_ff ^ opc_ff[4]) : (c_ff ^ opc_ff[4]);
  wire jump_go = (cls == C_JMP) || (cls == C_CALL) || (cls == C_ACCUMULATOR_JUMP) ||
                 (cls == C_JCC && cond_ok);
  wire [`PC_W-1:0] jump_tgt = cls == C_CALL ? call_tgt : cls == C_ACCUMULATOR_JUMP ? acc_tgt : near_tgt;
  wire tbl_rd = run && cls == C_TBL && s2;
  wire is_ret = cls == C_RET || cls == C_INTERRUPT_EXIT;

  // Program counter: advance per code byte, load on branches and returns.
  always_comb begin
    nxt_pc = pc_ff;
    if (phase_ff == PH_IRQ && s2) begin
      nxt_pc = irq_vector;
    end else if (run && (s0 || (s1 && two))) begin
      nxt_pc = pc_ff + 14'h0001;
    end else if (run && s2 && jump_go && cls != C_CALL) begin
      nxt_pc = jump_tgt;
    end else if (run && s3 && cls == C_CALL) begin
      // A call jumps one step late, so the second saved byte still holds the return page.
      nxt_pc = call_tgt;
    end else if (run && s3 && is_ret) begin
      nxt_pc = {hold_ff[`B2_PC_HI:0], ram_rdata};
    end
  end

  // Increment or decrement of accumulator, temporary or memory byte.
  wire [7:0] id_src = tgt == 2'h1 ? acc_ff : tgt == 2'h2 ? x_ff : ram_rdata;
  wire [8:0] id_r = cls == C_INC ? {1'b0, id_src} + 9'h001 : {1'b0, id_src} - 9'h001;

  // RAM port steering; one access per cycle is enough for every sequence.
  always_comb begin
    ram_we = 1'b0;
    ram_addr = ea;
    ram_wdata = acc_ff;
    if (phase_ff == PH_IRQ) begin
      ram_addr = psp_ff;
      ram_we = s0 || s1;
      ram_wdata = s0 ? byte1 : byte2;
    end else if (run) begin
      case (cls)
        C_PUSH: begin
          ram_addr = dsp_ff - 8'h01;
          ram_we = s1;
          ram_wdata = opc_ff[0] ? acc_ff : x_ff;
        end
        C_POP: ram_addr = dsp_ff;
        C_ST: ram_we = s2;
        C_RMW: begin
          ram_we = s3;
          ram_wdata = alu_r[7:0];
        end
        C_INC, C_DEC: begin
          ram_we = s3 && id_mem;
          ram_wdata = id_r[7:0];
        end
        C_CALL: begin
          ram_addr = psp_ff;
          ram_we = s2 || s3;
          ram_wdata = s2 ? byte1 : byte2;
        end
        C_RET, C_INTERRUPT_EXIT: ram_addr = psp_ff - 8'h01;
        default: ram_addr = ea;
      endcase
    end
  end

  // Accumulator arithmetic; read-modify-write takes memory as first operand.
  wire [7:0] alu_a = cls == C_RMW ? ram_rdata : acc_ff;
  wire [7:0] alu_b = cls == C_RMW ? acc_ff : opnd_val;
  always_comb begin
    unique case (sel)
      3'h0: alu_r = {1'b0, alu_a} + {1'b0, alu_b};
      3'h1: alu_r = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, c_ff};
      3'h3: alu_r = {1'b0, alu_a} - {1'b0, alu_b} - {8'h00, c_ff};
      3'h4: alu_r = {c_ff, alu_a | alu_b};
      3'h5: alu_r = {c_ff, alu_a & alu_b};
      3'h6: alu_r = {c_ff, alu_a ^ alu_b};
      // Subtract and compare share the borrow-out carry.
      default: alu_r = {1'b0, alu_a} - {1'b0, alu_b};
    endcase
  end

  // Complement, shifts and rotates through carry.
  always_comb begin
    unique case (opc_ff[2:0])
      3'h2: sh_r = {c_ff, ~acc_ff};
      3'h3: sh_r = {acc_ff, 1'b0};
      3'h4: sh_r = {acc_ff[0], acc_ff[7], acc_ff[7:1]};
      3'h5: sh_r = {acc_ff, c_ff};
      default: sh_r = {acc_ff[0], c_ff, acc_ff[7:1]};
    endcase
  end

  // The 256-byte data RAM shared by both stacks and variables.
  data_ram #(.AW(8), .DW(8)) u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata_ff(ram_rdata)
  );

  // Sequencer, fetch addressing and port strobes.
  always_ff @(posedge core_clk or negedge sync_nrst_ff) begin
    if (!sync_nrst_ff) begin
      phase_ff <= PH_RUN;
      step_ff <= `STEP_FETCH;
      pc_ff <= `PC_RESET;
      rom_addr_ff <= `PC_RESET;
      opc_ff <= 8'h20;
      opnd_ff <= 8'h00;
      io_addr_ff <= 8'h00;
      io_wdata_ff <= 8'h00;
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      irq_ack_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      // The table lookup borrows the fetch address for one cycle.
      rom_addr_ff <= tbl_rd ? acc_tgt : nxt_pc;
      if (phase_ff != PH_HALT) begin
        step_ff <= last ? `STEP_FETCH : step_ff + 4'h1;
      end
      if (last && run) begin
        phase_ff <= cls == C_HALT ? PH_HALT : (irq_req && int_en_ff) ? PH_IRQ : PH_RUN;
      end else if (last) begin
        phase_ff <= PH_RUN;
      end
      halted_ff <= (last && run && cls == C_HALT) || halted_ff;
      if (run && s0) begin
        opc_ff <= rom_data;
      end
      if (run && s1 && two) begin
        opnd_ff <= rom_data;
      end
      // Port cycles strobe for exactly one clock after the memory step.
      io_rd_ff <= run && s2 && cls == C_IO_READ_OP;
      io_wr_ff <= run && s2 && (cls == C_IO_WRITE_OP || cls == C_INDEXED_IO_WRITE_OP);
      if (run && s2 && (cls == C_IO_READ_OP || cls == C_IO_WRITE_OP || cls == C_INDEXED_IO_WRITE_OP)) begin
        io_addr_ff <= cls == C_INDEXED_IO_WRITE_OP ? opnd_ff + x_ff : opnd_ff;
        io_wdata_ff <= acc_ff;
      end
      irq_ack_ff <= phase_ff == PH_IRQ && s2;
    end
  end

  // Registers, flags, stack pointers and the interrupt mask.
  always_ff @(posedge core_clk or negedge sync_nrst_ff) begin
    if (!sync_nrst_ff) begin
      acc_ff <= 8'h00;
      x_ff <= 8'h00;
      dsp_ff <= `SP_RESET;
      psp_ff <= `SP_RESET;
      hold_ff <= 8'h00;
      c_ff <= 1'b0;
      z_ff <= 1'b0;
      int_en_ff <= 1'b0;
    end else if (phase_ff == PH_IRQ) begin
      // Mask while pushing the first byte, then push the second, both upward.
      if (s0) begin
        int_en_ff <= 1'b0;
      end
      if (s0 || s1) begin
        psp_ff <= psp_ff + 8'h01;
      end
    end else if (run) begin
      if (ex && cls == C_ALU) begin
        if (sel != 3'h7) begin
          acc_ff <= alu_r[7:0];
        end
        c_ff <= alu_r[8];
        z_ff <= alu_r[7:0] == 8'h00;
      end
      if (ex && cls == C_RMW) begin
        z_ff <= alu_r[7:0] == 8'h00;
      end
      if (ex && cls == C_LDA) begin
        acc_ff <= opnd_val;
      end
      if (ex && cls == C_LDX) begin
        x_ff <= opnd_val;
      end
      if (ex && (cls == C_INC || cls == C_DEC)) begin
        if (tgt == 2'h1) begin
          acc_ff <= id_r[7:0];
        end else if (tgt == 2'h2) begin
          x_ff <= id_r[7:0];
        end
        c_ff <= id_r[8];
        z_ff <= id_r[7:0] == 8'h00;
      end
      if (ex && cls == C_SHF) begin
        acc_ff <= sh_r[7:0];
        c_ff <= sh_r[8];
        z_ff <= sh_r[7:0] == 8'h00;
      end
      // Swaps and register moves.
      if (ex && (cls == C_SWX || cls == C_MAX)) begin
        acc_ff <= x_ff;
      end
      if (ex && (cls == C_SWX || cls == C_MXA)) begin
        x_ff <= acc_ff;
      end
      if (ex && cls == C_SWD) begin
        acc_ff <= dsp_ff;
        dsp_ff <= acc_ff;
      end
      // The stack pointer can be loaded but never read back.
      if (ex && cls == C_MPSP) begin
        psp_ff <= acc_ff;
      end
      if (ex && (cls == C_DI || cls == C_EI)) begin
        int_en_ff <= cls == C_EI;
      end
      if (cls == C_IO_READ_OP && s3) begin
        acc_ff <= io_rdata;
      end
      if (cls == C_TBL && s3) begin
        acc_ff <= rom_data;
      end
      if (cls == C_PUSH && s1) begin
        dsp_ff <= dsp_ff - 8'h01;
      end
      if (cls == C_POP && s2) begin
        dsp_ff <= dsp_ff + 8'h01;
        if (opc_ff[0]) begin
          acc_ff <= ram_rdata;
        end else begin
          x_ff <= ram_rdata;
        end
      end
      if (cls == C_CALL && (s2 || s3)) begin
        psp_ff <= psp_ff + 8'h01;
      end
      if (is_ret && (s1 || s2)) begin
        psp_ff <= psp_ff - 8'h01;
      end
      if (is_ret && s2) begin
        hold_ff <= ram_rdata;
      end
      // Only the interrupt exit restores flags, and it unmasks in the same step.
      if (cls == C_INTERRUPT_EXIT && s3) begin
        c_ff <= hold_ff[`B2_CARRY];
        z_ff <= hold_ff[`B2_ZERO];
        int_en_ff <= 1'b1;
      end
    end
  end

  // Checks on the sequences above.
  localparam int CALL_LAST = 9;
  localparam int RET_LAST = 7;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!sync_nrst_ff);

  a_io_read_acc: assert property (io_rd_ff |=> acc_ff == $past(io_rdata))
    else $error("port read did not load accumulator");
  a_io_write_data: assert property (run && s2 && cls == C_IO_WRITE_OP |=>
    io_wr_ff && io_addr_ff == $past(opnd_ff) && io_wdata_ff == $past(acc_ff))
    else $error("port write address or data wrong");
  a_indexed_io_write_op_addr: assert property (run && s2 && cls == C_INDEXED_IO_WRITE_OP |=>
    io_wr_ff && io_addr_ff == 8'($past(opnd_ff) + $past(x_ff)))
    else $error("indexed port address wrong");
  a_step_in_len: assert property (run |-> step_ff < len)
    else $error("step beyond instruction length");
  a_alu_idx_addr: assert property (run && s2 && cls == C_ALU && idx |->
    ram_addr == 8'(opnd_ff + x_ff))
    else $error("indexed operand address wrong");
  a_push_predec: assert property (run && s1 && cls == C_PUSH |->
    (ram_we && ram_addr == 8'(dsp_ff - 8'h01)) ##1 dsp_ff == 8'($past(dsp_ff) - 8'h01))
    else $error("push did not predecrement");
  a_call_psp_two: assert property (run && cls == C_CALL && step_ff == 4'h9 |->
    psp_ff == 8'($past(psp_ff, CALL_LAST) + 8'h02))
    else $error("call did not advance stack by two");
  a_ret_keep_flags: assert property (run && cls == C_RET && step_ff == 4'h7 |->
    psp_ff == 8'($past(psp_ff, RET_LAST) - 8'h02) && c_ff == $past(c_ff, RET_LAST))
    else $error("subroutine exit stack or flags wrong");
  a_irq_save: assert property (phase_ff == PH_IRQ && s0 |->
    (ram_we && ram_addr == psp_ff) ##1 (!int_en_ff && ram_we && ram_addr == psp_ff))
    else $error("interrupt entry save wrong");
  a_interrupt_exit_unmask: assert property (run && cls == C_INTERRUPT_EXIT && s3 |=> int_en_ff)
    else $error("interrupt exit did not unmask");

  c_call: cover property (run && cls == C_CALL && s3);
  c_irq_entry: cover property (irq_ack_ff);
  c_interrupt_exit: cover property (run && cls == C_INTERRUPT_EXIT && s3);
  c_halt: cover property ($rose(halted_ff));
endmodule

// [verilog/cpu_core_regs.svh]
// Constants of the instruction decoder core: reset values, step numbers, cycle counts, layouts.
// Notes on behaviour
// - Port read loads accumulator; port write stores it.
// - Indexed port write addresses operand plus temporary.
// - Accumulator arithmetic groups decoded in threes, timed.
// - Moves, prefix and reserved opcode decoded, timed.
// - Branch opcodes carry address bits, timed.
// - Increment and decrement forms decoded, timed.
// - Memory stores and read-modify-write decoded, timed.
// - Push predecrements pointer; pop postincrements it.
// - Single-byte operations decoded with their timings.
// - Program stack pointer resets zero, write-only.
// - Interrupt entry masks, saves two bytes upward.
// - Interrupt exit restores both bytes and unmasks in the same step.
// - Call saves counter and flags like interrupts.
// - Subroutine exit restores counter, keeps flags.
// - Data stack pointer resets zero, wraps.
// - Immediate constant is the second code byte.
// - Data RAM holds 256 bytes.
// - Direct mode uses operand as RAM address.
// - Indexed mode adds operand and temporary register.
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH
`define PC_W 14
`define PC_RESET 14'h0000
`define SP_RESET 8'h00
`define STEP_FETCH 4'h0
`define STEP_OPND 4'h1
`define STEP_MEM 4'h2
`define STEP_EXM 4'h3
`define CYC_BASE 4'h4
`define CYC_SHORT 4'h5
`define CYC_MID 4'h6
`define CYC_LONG 4'h7
`define CYC_RMWX 4'h8
`define CYC_CALL 4'hA
`define CYC_TBL 4'hE
`define CYC_IRQ 4'h4
`define B2_CARRY 7
`define B2_ZERO 6
`define B2_PC_HI 5
`endif

// [verilog/cpu_pkg.sv]
// Package with the decoded instruction classes and the core phases.
package cpu_pkg;
  typedef enum logic [4:0] {
    C_NOP, C_HALT, C_ALU, C_LDA, C_LDX, C_INC, C_DEC, C_IO_READ_OP, C_IO_WRITE_OP, C_INDEXED_IO_WRITE_OP,
    C_POP, C_PUSH, C_SWX, C_SWD, C_ST, C_RMW, C_SHF, C_RET, C_INTERRUPT_EXIT, C_DI, C_EI,
    C_MAX, C_MXA, C_MPSP, C_XPG, C_CALL, C_JMP, C_JCC, C_ACCUMULATOR_JUMP, C_TBL
  } cls_t;
  typedef enum logic [1:0] {PH_RUN, PH_IRQ, PH_HALT} phase_t;
endpackage

// [verilog/data_ram.sv]
// Single-port data RAM with a registered read port.
`timescale 1ns/1ps
module data_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_ff
);
  // Storage; not reset, firmware must initialise what it reads.
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write on strobe; the read returns the old contents one clock later.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end
endmodule
